// ==== bridge_cfg_header_timeout_ctrl.sv ====
// Configuration header tail of a bridge: capability pointer, interrupt line/pin and
// the master timeout part of bridge control, with the two delayed-transaction timers.
// Assumes a config access port synchronous to the PCI clock, one-cycle strobes.
`timescale 1ns/10ps

module bridge_cfg_header_timeout_ctrl
  import bridge_tail_pkg::*;
#(
  parameter int LONG_LOG2  = LONG_PERIOD_LOG2,
  parameter int SHORT_LOG2 = SHORT_PERIOD_LOG2
)(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  cfg_rd_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic [7:0]            cfg_addr_i,
  input  wire logic [3:0]            cfg_be_b_i,
  input  wire logic [31:0]           cfg_wdata_i,
  input  wire logic                  cmd_syserr_enable_i,
  input  wire logic [NUM_TIMERS-1:0] completion_at_head_i,
  input  wire logic [NUM_TIMERS-1:0] retry_delivered_i,
  output logic      [31:0]           cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  output logic      [NUM_TIMERS-1:0] discard_o,
  output logic                       primary_system_error_out_o
);

  // Elaboration checks: the limit must fit the counter, and only two timers are wired.
  if (LONG_LOG2 < 1 || LONG_LOG2 >= TIMER_WIDTH)
  begin : g_bad_long
    $error("Long timeout exponent does not fit the timer counter.");
  end
  if (SHORT_LOG2 < 1 || SHORT_LOG2 > LONG_LOG2)
  begin : g_bad_short
    $error("Short timeout exponent out of range.");
  end
  if (NUM_TIMERS != 2)
  begin : g_bad_count
    $error("Period select wiring serves exactly two timers.");
  end

  localparam logic [TIMER_WIDTH-1:0] LONG_LIMIT  = TIMER_WIDTH'(1 << LONG_LOG2);
  localparam logic [TIMER_WIDTH-1:0] SHORT_LIMIT = TIMER_WIDTH'(1 << SHORT_LOG2);

  // Word decode: the two low address bits pick a byte, not a register.
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] offs);
    hits = (addr[7:2] == offs[7:2]);
  endfunction

  // A byte lane of the combined word is written when its enable is low.
  function automatic logic lane_write(input logic       wr,
                                      input logic [7:0] addr,
                                      input logic [3:0] be_b,
                                      input int         lane);
    lane_write = wr && hits(addr, INT_BRIDGE_OFFSET) && !be_b[lane];
  endfunction

  logic rst_sync1_reg;
  logic rst_sync2_reg;

  // The reset is released through two flops; nothing else reads the first one.
  // It runs free of the clock enable so that a frozen block still leaves reset.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  logic                    rst_n;
  assign rst_n = rst_sync2_reg;

  logic [7:0]              int_line_reg;
  logic [7:0]              int_line_next;
  logic                    pri_short_reg;
  logic                    pri_short_next;
  logic                    sec_short_reg;
  logic                    sec_short_next;
  logic                    expiry_status_reg;
  logic                    expiry_status_next;
  logic                    syserr_en_reg;
  logic                    syserr_en_next;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  logic                    rvalid_reg;
  logic                    rvalid_next;
  logic                    serr_reg;
  logic                    serr_next;
  logic [NUM_TIMERS-1:0]   expire;
  logic [NUM_TIMERS-1:0]   short_sel;

  assign short_sel[TIMER_PRIMARY]   = pri_short_reg;
  assign short_sel[TIMER_SECONDARY] = sec_short_reg;

  // Register file: byte writes and the status update.
  always_comb
  begin
    logic wr_ctrl;
    logic wr_line;
    wr_ctrl = lane_write(cfg_wr_i, cfg_addr_i, cfg_be_b_i, BYTE_LANE_CTRL);
    wr_line = lane_write(cfg_wr_i, cfg_addr_i, cfg_be_b_i, BYTE_LANE_LINE);
    int_line_next      = int_line_reg;
    pri_short_next     = pri_short_reg;
    sec_short_next     = sec_short_reg;
    expiry_status_next = expiry_status_reg;
    syserr_en_next     = syserr_en_reg;
    if (wr_line)
    begin
      int_line_next = cfg_wdata_i[INT_LINE_LSB +: 8];
    end
    if (wr_ctrl)
    begin
      pri_short_next = cfg_wdata_i[BIT_PRI_SHORT];
      sec_short_next = cfg_wdata_i[BIT_SEC_SHORT];
      syserr_en_next = cfg_wdata_i[BIT_SYSERR_ENABLE];
      if (cfg_wdata_i[BIT_EXPIRY_STATUS])
      begin
        expiry_status_next = 1'b0;
      end
    end
    // An expiry in the same cycle as a clearing write must not be lost.
    // Expiry sets, winning over clear.
    if (|expire)
    begin
      expiry_status_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_line_reg      <= INT_LINE_RESET;
      pri_short_reg     <= BRIDGE_CTRL_RESET[BIT_PRI_SHORT];
      sec_short_reg     <= BRIDGE_CTRL_RESET[BIT_SEC_SHORT];
      expiry_status_reg <= BRIDGE_CTRL_RESET[BIT_EXPIRY_STATUS];
      syserr_en_reg     <= BRIDGE_CTRL_RESET[BIT_SYSERR_ENABLE];
    end
    else if (clk_en_i)
    begin
      int_line_reg      <= int_line_next;
      pri_short_reg     <= pri_short_next;
      sec_short_reg     <= sec_short_next;
      expiry_status_reg <= expiry_status_next;
      syserr_en_reg     <= syserr_en_next;
    end
  end

  // Response path: read word, read strobe and the error pulse.
  always_comb
  begin
    // Error pulse gated by both enables.
    serr_next   = (|expire) && syserr_en_reg && cmd_syserr_enable_i;
    rvalid_next = cfg_rd_i;
    // The read word holds until the next read, so a late sample still sees it.
    rdata_next  = rdata_reg;
    if (cfg_rd_i)
    begin
      // A read of an unmapped word returns zero.
      rdata_next = '0;
      if (hits(cfg_addr_i, CAP_PTR_OFFSET))
      begin
        rdata_next[CAP_PTR_LSB +: 8] = CAP_PTR_VALUE;
      end
      else if (hits(cfg_addr_i, INT_BRIDGE_OFFSET))
      begin
        rdata_next[INT_LINE_LSB +: 8]  = int_line_reg;
        rdata_next[INT_PIN_LSB +: 8]   = INT_PIN_VALUE;
        rdata_next[BIT_PRI_SHORT]      = pri_short_reg;
        rdata_next[BIT_SEC_SHORT]      = sec_short_reg;
        rdata_next[BIT_EXPIRY_STATUS]  = expiry_status_reg;
        rdata_next[BIT_SYSERR_ENABLE]  = syserr_en_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      serr_reg   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      serr_reg   <= serr_next;
    end
  end

  // One timer per bus; index 0 primary, index 1 secondary.
  generate
    for (genvar t = 0; t < NUM_TIMERS; t++)
    begin : g_timer
      timer_state_t           state_reg;
      timer_state_t           state_next;
      logic [TIMER_WIDTH-1:0] count_reg;
      logic [TIMER_WIDTH-1:0] count_next;
      logic                   discard_reg;
      logic                   discard_next;
      logic [TIMER_WIDTH-1:0] limit;

      assign limit = short_sel[t] ? SHORT_LIMIT : LONG_LIMIT;
      // The registered discard feeds the status flag and the error pulse.
      assign expire[t] = discard_reg;

      always_comb
      begin
        state_next   = state_reg;
        count_next   = count_reg;
        discard_next = 1'b0;
        case (state_reg)
          TIMER_IDLE:
          begin
            // The start edge counts as cycle one, so discard comes one period later.
            // Start at queue head.
            if (completion_at_head_i[t])
            begin
              state_next = TIMER_WAIT;
              count_next = TIMER_WIDTH'(1);
            end
          end
          TIMER_WAIT:
          begin
            // Further completions while waiting are ignored until this one ends.
            // Retry stops timer.
            if (retry_delivered_i[t])
            begin
              state_next = TIMER_IDLE;
              count_next = '0;
            end
            else if (count_reg >= limit)
            begin
              state_next   = TIMER_IDLE;
              count_next   = '0;
              discard_next = 1'b1;
            end
            else
            begin
              count_next = count_reg + TIMER_WIDTH'(1);
            end
          end
          default:
          begin
            state_next = TIMER_IDLE;
            count_next = '0;
          end
        endcase
      end

      always_ff @(posedge ref_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          state_reg   <= TIMER_IDLE;
          count_reg   <= '0;
          discard_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
          state_reg   <= state_next;
          count_reg   <= count_next;
          discard_reg <= discard_next;
        end
      end

      assign discard_o[t] = discard_reg;
    end
  endgenerate

  assign cfg_rdata_o                = rdata_reg;
  assign cfg_rvalid_o               = rvalid_reg;
  assign primary_system_error_out_o = serr_reg;

endmodule // bridge_cfg_header_timeout_ctrl

// ==== bridge_tail_pkg.sv ====
// Package for the bridge configuration header tail: offsets, fields, reset values, periods.
// Assumes a 32-bit configuration data path with active-low byte enables.
package bridge_tail_pkg;
  localparam logic [7:0]  CAP_PTR_OFFSET     = 8'h34;
  localparam logic [7:0]  INT_BRIDGE_OFFSET  = 8'h3c;
  localparam logic [7:0]  CAP_PTR_VALUE      = 8'hdc;
  localparam logic [7:0]  INT_LINE_RESET     = 8'hff;
  localparam logic [7:0]  INT_PIN_VALUE      = 8'h00;
  localparam int          CAP_PTR_LSB        = 0;
  localparam int          INT_PIN_LSB        = 8;
  localparam logic [31:0] BRIDGE_CTRL_RESET  = 32'h0000_0000;
  localparam int          BIT_PRI_SHORT      = 24;
  localparam int          BIT_SEC_SHORT      = 25;
  localparam int          BIT_EXPIRY_STATUS  = 26;
  localparam int          BIT_SYSERR_ENABLE  = 27;
  localparam int          INT_LINE_LSB       = 0;
  localparam int          BYTE_LANE_CTRL     = 3;
  localparam int          BYTE_LANE_LINE     = 0;
  localparam int          LONG_PERIOD_LOG2   = 15;
  localparam int          SHORT_PERIOD_LOG2  = 10;
  localparam int          TIMER_WIDTH        = LONG_PERIOD_LOG2 + 1;
  localparam int          NUM_TIMERS         = 2;
  localparam int          TIMER_PRIMARY      = 0;
  localparam int          TIMER_SECONDARY    = 1;
  typedef enum logic [0:0] {
    TIMER_IDLE,
    TIMER_WAIT
  } timer_state_t;
endpackage

// ==== bridge_tail_checker.sv ====
// Port-level timing checks for the bridge header tail and its master timeout timers.
// Assumes it is bound to the top module and inherits its period parameters.
`timescale 1ns/10ps
module bridge_tail_checker #(
  parameter int LONG_LOG2  = 15,
  parameter int SHORT_LOG2 = 10
)(
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic        cmd_syserr_enable_i,
  input wire logic [1:0]  completion_at_head_i,
  input wire logic [1:0]  retry_delivered_i,
  input wire logic [1:0]  discard_o,
  input wire logic        primary_system_error_out_o
);
  localparam int LP = (1 << LONG_LOG2) + 1;
  localparam int SP = (1 << SHORT_LOG2) + 1;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rv; cfg_rd_i |=> cfg_rvalid_o; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_cap; cfg_rd_i && cfg_addr_i == 8'h34 |=> cfg_rdata_o == 32'h0000_00dc; endproperty
  a_cap: assert property (p_cap) else $error("pointer word wrong");
  property p_pin; cfg_rd_i && cfg_addr_i == 8'h3c |=> cfg_rdata_o[31:28] == 4'h0
    && cfg_rdata_o[23:8] == 16'h0000; endproperty
  a_pin: assert property (p_pin) else $error("pin or reserved bits set");
  property p_serr; primary_system_error_out_o |-> $past(discard_o) != 2'b00
    && $past(cmd_syserr_enable_i); endproperty
  a_serr: assert property (p_serr) else $error("system error without cause");
  property p_spl; primary_system_error_out_o |=> !primary_system_error_out_o; endproperty
  a_spl: assert property (p_spl) else $error("system error too long");
  property p_sdis; discard_o[1] |-> $past(completion_at_head_i[1], SP)
    || $past(completion_at_head_i[1], LP); endproperty
  a_sdis: assert property (p_sdis) else $error("secondary period wrong");
  property p_pdis; discard_o[0] |-> $past(completion_at_head_i[0], SP)
    || $past(completion_at_head_i[0], LP); endproperty
  a_pdis: assert property (p_pdis) else $error("primary period wrong");
  property p_dpl; discard_o[0] |=> !discard_o[0]; endproperty
  a_dpl: assert property (p_dpl) else $error("discard too long");
  property p_stop; retry_delivered_i[1] |=> (!discard_o[1]) [*8]; endproperty
  a_stop: assert property (p_stop) else $error("discard after retry");
endmodule // bridge_tail_checker

bind bridge_cfg_header_timeout_ctrl bridge_tail_checker #(.LONG_LOG2(LONG_LOG2),
  .SHORT_LOG2(SHORT_LOG2)) i_bridge_tail_checker (.ref_clk_i, .rst_b_i, .cfg_rd_i,
  .cfg_addr_i, .cfg_rdata_o, .cfg_rvalid_o, .cmd_syserr_enable_i, .completion_at_head_i,
  .retry_delivered_i, .discard_o, .primary_system_error_out_o);

// ==== far_initiator_model.sv ====
// Far-side initiator model: puts completions at the queue head and retries on command.
// Assumes the bench calls its tasks; lines change on the falling clock edge.
`timescale 1ns/10ps
module far_initiator_model (
  input  wire logic       ref_clk_i,
  output logic      [1:0] completion_at_head_o = 2'b00,
  output logic      [1:0] retry_delivered_o = 2'b00
);
  task automatic raise(input int t);
    @(negedge ref_clk_i) completion_at_head_o[t] = 1'b1;
    @(negedge ref_clk_i) completion_at_head_o[t] = 1'b0;
  endtask
  task automatic retry(input int t);
    @(negedge ref_clk_i) retry_delivered_o[t] = 1'b1;
    @(negedge ref_clk_i) retry_delivered_o[t] = 1'b0;
  endtask
endmodule // far_initiator_model

// ==== bridge_cfg_header_timeout_ctrl_tb.sv ====
// Self-checking bench for the header tail registers and the master timeout timers.
// Assumes test periods of 2^5 and 2^3 cycles and a 200 MHz clock.
`timescale 1ns/10ps
module bridge_cfg_header_timeout_ctrl_tb;
  localparam int LG = 5;
  localparam int SH = 3;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [3:0]  be_b = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic        cmd_en = 1'b0;
  logic        en = 1'b1;
  logic [1:0]  head;
  logic [1:0]  retry;
  logic [31:0] rdata;
  logic        rvalid;
  logic [1:0]  discard;
  logic        serr;
  logic [31:0] line = 32'hff;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  bridge_cfg_header_timeout_ctrl #(.LONG_LOG2(LG), .SHORT_LOG2(SH))
    i_bridge_cfg_header_timeout_ctrl (.ref_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
    .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_b_i(be_b), .cfg_wdata_i(wdata),
    .cmd_syserr_enable_i(cmd_en), .completion_at_head_i(head), .retry_delivered_i(retry),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .discard_o(discard),
    .primary_system_error_out_o(serr));
  far_initiator_model i_far_initiator_model (.ref_clk_i(clk),
    .completion_at_head_o(head), .retry_delivered_o(retry));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, exp);
  endtask
  task automatic wr_do(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    be_b = b;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    be_b = 4'hf;
  endtask
  function automatic logic [31:0] ctl(input logic e, input logic s, input logic sh);
    return {4'h0, e, s, sh, sh, 24'h0};
  endfunction
  task automatic t_regs;
    rd_chk(8'h34, 32'h0000_00dc);
    rd_chk(8'h3c, 32'h0000_00ff);
    wr_do(8'h3c, 4'h0, 32'hffff_ff5a);
    rd_chk(8'h3c, 32'h0b00_005a);
    wr_do(8'h3c, 4'h7, 32'h0);
    rd_chk(8'h3c, 32'h0000_005a);
    wr_do(8'h34, 4'h0, 32'hffff_ffff);
    rd_chk(8'h34, 32'h0000_00dc);
    rd_chk(8'h40, 32'h0);
    wr_do(8'h3c, 4'he, 32'hffff_ffff);
    rd_chk(8'h3c, 32'h0000_00ff);
    $display("register test done");
  endtask
  task automatic t_freeze;
    en = 1'b0;
    wr_do(8'h3c, 4'he, 32'h0);
    en = 1'b1;
    rd_chk(8'h3c, line);
    $display("freeze test done");
  endtask
  task automatic t_expire(input int t, input logic sh, input logic e, input logic c);
    int n;
    n = 0;
    cmd_en = c;
    wr_do(8'h3c, 4'h7, ctl(e, 1'b0, sh));
    i_far_initiator_model.raise(t);
    while (discard[t] !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, 1 << (sh ? SH : LG));
    @(negedge clk);
    chk({31'h0, serr}, {31'h0, e & c});
    wr_do(8'h3c, 4'h7, ctl(e, 1'b0, sh));
    rd_chk(8'h3c, ctl(e, 1'b1, sh) | line);
    wr_do(8'h3c, 4'h7, ctl(e, 1'b1, sh));
    rd_chk(8'h3c, ctl(e, 1'b0, sh) | line);
    $display("expiry test done");
  endtask
  task automatic t_retry(input int t);
    logic seen;
    seen = 1'b0;
    cmd_en = 1'b1;
    wr_do(8'h3c, 4'h7, ctl(1'b1, 1'b0, 1'b1));
    i_far_initiator_model.raise(t);
    repeat (3) @(negedge clk);
    i_far_initiator_model.retry(t);
    repeat (20)
    begin
      @(negedge clk);
      seen = seen | discard[t] | serr;
    end
    chk({31'h0, seen}, 32'h0);
    rd_chk(8'h3c, ctl(1'b1, 1'b0, 1'b1) | line);
    $display("retry test done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_freeze();
    t_expire(0, 1'b0, 1'b1, 1'b1);
    t_expire(1, 1'b1, 1'b0, 1'b1);
    t_expire(1, 1'b0, 1'b1, 1'b0);
    t_expire(0, 1'b1, 1'b1, 1'b1);
    t_retry(1);
    t_retry(0);
    results();
  end
endmodule // bridge_cfg_header_timeout_ctrl_tb
